// >>> logic/prt_core.sv
// Function
// [R1] pulses keep totalising while menu is open
// [R2] rate is frequency over scale times timebase
// [R3] total is count over scale; feeds grand
// [R4] total recomputed twice per second
// [R5] cycle plus commit opens menu at update
// [R6] nonzero code shows prompt, digit entry
// [R7] wrong code or ten second idle exits
// [R8] up and down step through parameters
// [R9] defaults: open collector, scales one, seconds
// [R10] five input types selectable
// [R11] scale factors span 0.001 to 99999999
// [R12] timebase multiplies by 1, 60, 3600
// [R13] rate filter with two decimal digits
// [R14] no totalising below clip-off rate
// [R15] up plus down over 2s clears total
// [R16] grand total clear needs second confirmation
// [R17] four digit code, zero disables protection
// [R18] six display intervals, 0.5 to 5 s
// [R19] display interval affects displays only
// [R20] scale decimal point is part of value
// [R21] lower display can be switched off
// [R22] intervals 0.5, 1, 2, 3, 4, 5 s
//
// The register offsets and the AHB-Lite register port are this design's own decisions.
module prt_core import prt_pkg::*; #(
    parameter int HALF_CYC_P = HALF_CYC,
    parameter int TMO_CYC_P = TMO_CYC,
    parameter int LR_CYC_P = LR_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_en,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pulse_in,
    input wire logic btn_cycle,
    input wire logic btn_up,
    input wire logic btn_down,
    input wire logic btn_commit,
    output logic [31:0] disp_rate,
    output logic [31:0] disp_total,
    output logic lower_display_on,
    output logic hold_ind,
    output logic menu_on,
    output logic code_prompt,
    output logic [3:0] menu_sel
);
    // ----------------------------------------
    // decoders
    // ----------------------------------------
    function automatic logic [9:0] pow10(input logic [1:0] dp);
        case (dp)
            2'h0: pow10 = 10'h001;
            2'h1: pow10 = 10'h00A;
            2'h2: pow10 = 10'h064;
            default: pow10 = 10'h3E8;
        endcase
    endfunction : pow10

    function automatic logic [26:0] mant(input logic [31:0] sc);
        mant = (sc[26:0] == 27'h0) ? 27'h1 : sc[26:0];
    endfunction : mant

    function automatic logic [11:0] tbm(input logic [1:0] tb);
        case (tb)
            2'h1: tbm = 12'h03C;
            2'h2: tbm = 12'hE10;
            default: tbm = 12'h001;
        endcase
    endfunction : tbm

    function automatic logic [3:0] uph(input logic [2:0] u);
        case (u)
            3'h0: uph = 4'h1;
            3'h1: uph = 4'h2;
            3'h2: uph = 4'h4;
            3'h3: uph = 4'h6;
            3'h4: uph = 4'h8;
            default: uph = 4'hA;
        endcase
    endfunction : uph

    function automatic logic [6:0] pct(input logic [3:0] d);
        case (d)
            4'h1: pct = 7'h01;
            4'h2: pct = 7'h02;
            4'h3: pct = 7'h04;
            4'h4: pct = 7'h08;
            4'h5: pct = 7'h0C;
            4'h6: pct = 7'h10;
            4'h7: pct = 7'h18;
            4'h8: pct = 7'h20;
            4'h9: pct = 7'h40;
            default: pct = 7'h00;
        endcase
    endfunction : pct

    function automatic logic [2:0] wrap(input logic [2:0] v, input logic [2:0] mx,
                                        input logic up);
        if (up) begin
            wrap = (v >= mx) ? 3'h0 : v + 3'h1;
        end else begin
            wrap = (v == 3'h0 || v > mx) ? mx : v - 3'h1;
        end
    endfunction : wrap

    function automatic logic [3:0] dgt(input logic [3:0] v, input logic up);
        if (up) begin
            dgt = (v >= 4'h9) ? 4'h0 : v + 4'h1;
        end else begin
            dgt = (v == 4'h0 || v > 4'h9) ? 4'h9 : v - 4'h1;
        end
    endfunction : dgt

    // ----------------------------------------
    // state
    // ----------------------------------------
    prt_st_t r;
    prt_st_t n;
    logic [4:0] ed;
    logic pe;
    logic ht;
    logic both;
    logic clr_tot;
    logic acc;
    logic bit_q;
    logic [27:0] t;
    logic [26:0] m_r;
    logic [26:0] m_t;
    logic signed [32:0] df;
    logic [39:0] ab;

    always_comb begin
        n = r;
        ed = r.lv & ~r.lq;
        pe = ed[0];
        ht = (r.hc == 26'(HALF_CYC_P - 1));
        both = r.lv[1] & r.lv[4] & (ed[1] | ed[4]);
        clr_tot = 1'b0;
        acc = hsel & hready & htrans[1];
        bit_q = 1'b0;
        t = 28'h0;
        m_r = mant(r.cfg.rsc);
        m_t = mant(r.cfg.tsc);
        df = 33'sh0;
        ab = 40'h0;
        // pins: three stages, a change counts once stages 2 and 3 agree
        n.s1 = {btn_commit, btn_down, btn_up, btn_cycle, pulse_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.lv = (r.s2 & r.s3) | (r.lv & (r.s2 ^ r.s3));
        n.lq = r.lv;
        n.hc = ht ? 26'h0 : r.hc + 26'h1;
        // ----------------------------------------
        // rate: one second gate, then serial divide
        // ----------------------------------------
        if (pe) begin
            n.pc = r.pc + 16'h1;
        end
        if (ht) begin
            n.win = ~r.win;
            if (r.win) begin
                n.num = 48'(n.pc) * 48'(tbm(r.cfg.tb)) * 48'(pow10(r.cfg.rsc[SC_DP+:2])); // [R2] [R12] [R20]
                n.pc = 16'h0;
                n.rem = 28'h0;
                n.quo = 32'h0;
                n.dn = 6'h30;
                n.busy = 1'b1;
            end
        end
        if (r.busy) begin
            t = {r.rem[26:0], r.num[47]};
            bit_q = (t >= 28'(m_r)); // [R2] [R11]
            n.rem = bit_q ? t - 28'(m_r) : t;
            n.quo = {r.quo[30:0], bit_q};
            n.num = {r.num[46:0], 1'b0};
            n.dn = r.dn - 6'h1;
            if (r.dn == 6'h1) begin
                n.busy = 1'b0;
                df = $signed({1'b0, n.quo}) - $signed({1'b0, r.rflt});
                ab = 40'(df < 0 ? -df : df);
                // shift stands in for the time constant, a coarse but cheap filter
                if (r.cfg.f1 == 4'h0 || (r.cfg.f2 != 4'h0 &&
                    ab * 40'h64 > 40'(r.rflt) * 40'(pct(r.cfg.f2)))) begin // [R13]
                    n.rflt = n.quo;
                end else begin
                    n.rflt = 32'($signed({1'b0, r.rflt}) + (df >>> r.cfg.f1)); // [R13]
                end
            end
        end
        n.hold = (r.rflt < r.cfg.clip); // [R14]
        // ----------------------------------------
        // total, counting independent of menu state; local clear only in S_DISP
        // ----------------------------------------
        if (pe) begin
            if (!r.hold) begin
                n.tacc = r.tacc + 28'(pow10(r.cfg.tsc[SC_DP+:2])); // [R1] [R3] [R14]
            end
        end else if (r.tacc >= 28'(m_t)) begin
            n.tacc = r.tacc - 28'(m_t); // [R3] [R11]
            n.tcnt = r.tcnt + 32'h1;
        end
        if (ht) begin
            n.tot = r.tcnt; // [R4]
            n.gt = r.gt + 64'(r.tcnt - r.tot); // [R3]
            // display refresh only; totals and rate run at their own pace
            if (r.dc + 4'h1 >= uph(r.cfg.upd)) begin // [R18] [R19] [R22]
                n.dc = 4'h0;
                n.d_rate = r.rflt;
                n.d_tot = r.tot;
            end else begin
                n.dc = r.dc + 4'h1;
            end
        end
        // local clear from the front buttons
        if (r.st == S_DISP && r.lv[2] && r.lv[3] && r.cfg.locen) begin
            if (r.lrc == 28'(LR_CYC_P - 1)) begin
                clr_tot = 1'b1; // [R15]
            end else begin
                n.lrc = r.lrc + 28'h1;
            end
        end else begin
            n.lrc = 28'h0;
        end
        if (clr_tot) begin
            n.tcnt = 32'h0;
            n.tot = 32'h0;
            n.tacc = 28'h0;
        end
        // ----------------------------------------
        // menu
        // ----------------------------------------
        case (r.st)
            S_DISP: begin
                if (both) begin
                    n.par = P_UPD;
                    n.cin = 16'h0;
                    n.dig = 2'h0;
                    n.prm = 1'b1;
                    n.tmo = 30'h0;
                    n.st = (r.cfg.code == 16'h0) ? S_MENU : S_CODE; // [R5] [R6] [R17]
                end
            end
            S_CODE: begin
                n.tmo = (|ed[4:1]) ? 30'h0 : r.tmo + 30'h1;
                if (ed[1]) begin
                    n.prm = 1'b0;
                    n.dig = r.prm ? 2'h0 : r.dig + 2'h1; // [R6]
                end
                if (!r.prm && (ed[2] || ed[3])) begin
                    n.cin[r.dig*4+:4] = dgt(r.cin[r.dig*4+:4], ed[2]); // [R6]
                end
                if (ed[4]) begin
                    n.st = (r.cin == r.cfg.code) ? S_MENU : S_DISP; // [R6] [R7]
                end
                if (r.tmo == 30'(TMO_CYC_P - 1)) begin
                    n.st = S_DISP; // [R7]
                end
            end
            S_MENU: begin
                if (ed[2]) begin
                    n.par = (r.par == P_UPD) ? P_LAST : r.par - 4'h1; // [R8]
                end else if (ed[3]) begin
                    n.par = (r.par == P_LAST) ? P_UPD : r.par + 4'h1; // [R8]
                end else if (ed[1]) begin
                    n.st = (r.par == P_CLR) ? S_CONF : S_EDIT; // [R16]
                end else if (ed[4]) begin
                    n.st = S_DISP;
                end
            end
            S_EDIT: begin
                if (ed[2] || ed[3]) begin
                    case (r.par)
                        P_UPD: n.cfg.upd = wrap(r.cfg.upd, N_UPD, ed[2]); // [R18]
                        P_TYPE: n.cfg.itype = wrap(r.cfg.itype, IT_OC, ed[2]); // [R10]
                        P_LOW: n.cfg.lower = ~r.cfg.lower; // [R21]
                        P_TB: n.cfg.tb = 2'(wrap(3'(r.cfg.tb), N_TB, ed[2])); // [R12]
                        P_LOC: n.cfg.locen = ~r.cfg.locen;
                        default: n.cfg = r.cfg;
                    endcase
                end
                if (ed[1] || ed[4]) begin
                    n.st = S_MENU;
                end
            end
            S_CONF: begin
                if (ed[4]) begin
                    n.gt = 64'h0; // [R16]
                    n.st = S_MENU;
                end else if (ed[1]) begin
                    n.st = S_MENU;
                end
            end
            default: n.st = S_DISP;
        endcase
        // ----------------------------------------
        // bus slave, zero wait states
        // ----------------------------------------
        n.a_wr = acc & hwrite;
        n.a_adr = haddr[7:0];
        n.rdy = 1'b1;
        n.rsp = 1'b0;
        if (acc && !hwrite) begin
            case (haddr[7:0])
                A_CFG: n.rdata = {8'h0, r.cfg.f2, r.cfg.f1, 2'h0, r.cfg.locen,
                    r.cfg.lower, 1'b0, r.cfg.upd, 2'h0, r.cfg.tb, 1'b0, r.cfg.itype};
                A_RSC: n.rdata = r.cfg.rsc;
                A_TSC: n.rdata = r.cfg.tsc;
                A_CLIP: n.rdata = r.cfg.clip;
                A_CODE: n.rdata = {16'h0, r.cfg.code};
                A_RATE: n.rdata = r.rflt;
                A_TOT: n.rdata = r.tot;
                A_GTL: n.rdata = r.gt[31:0];
                A_GTH: n.rdata = r.gt[63:32];
                A_STAT: n.rdata = {22'h0, r.hold, r.st, r.par};
                default: n.rdata = 32'h0;
            endcase
        end
        if (r.a_wr) begin
            case (r.a_adr)
                A_CFG: begin
                    n.cfg.itype = (hwdata[F_TYPE+:3] > IT_OC) ? IT_OC : hwdata[F_TYPE+:3];
                    n.cfg.tb = (hwdata[F_TB+:2] == 2'h3) ? 2'h2 : hwdata[F_TB+:2];
                    n.cfg.upd = (hwdata[F_UPD+:3] > N_UPD) ? N_UPD : hwdata[F_UPD+:3];
                    n.cfg.lower = hwdata[F_LOW];
                    n.cfg.locen = hwdata[F_LOC];
                    n.cfg.f1 = hwdata[F_F1+:4];
                    n.cfg.f2 = hwdata[F_F2+:4];
                end
                A_RSC: n.cfg.rsc = {2'h0, hwdata[SC_DP+:2], 1'b0, hwdata[26:0]}; // [R11] [R20]
                A_TSC: n.cfg.tsc = {2'h0, hwdata[SC_DP+:2], 1'b0, hwdata[26:0]}; // [R11] [R20]
                A_CLIP: n.cfg.clip = hwdata;
                A_CODE: n.cfg.code = hwdata[15:0]; // [R17]
                default: ;
            endcase
        end
        n.mon = (n.st != S_DISP);
        n.cpr = n.prm && (n.st == S_CODE);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.st <= S_DISP;
            r.cfg <= CFG_RST; // [R9]
            r.rdy <= 1'b1;
        end else if (clk_en) begin
            r <= n;
        end
    end
    assign hreadyout = r.rdy;
    assign hresp = r.rsp;
    assign hrdata = r.rdata;
    assign disp_rate = r.d_rate;
    assign disp_total = r.d_tot;
    assign lower_display_on = r.cfg.lower; // [R21]
    assign hold_ind = r.hold;
    assign menu_on = r.mon;
    assign code_prompt = r.cpr;
    assign menu_sel = r.par;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn || !clk_en);

    a_menu_open: assert property (r.st == S_DISP && both && r.cfg.code == 16'h0 // [R5]
        |=> r.st == S_MENU && r.par == P_UPD) else $error("menu did not open");
    a_code_prompt: assert property (r.st == S_DISP && both && r.cfg.code != 16'h0 // [R6]
        |=> r.st == S_CODE && r.prm) else $error("code prompt missing");
    a_code_idle: assert property (r.st == S_CODE && r.tmo == 30'(TMO_CYC_P - 1) // [R7]
        |=> r.st == S_DISP) else $error("code entry did not time out");
    a_code_wrong: assert property (r.st == S_CODE && ed[4] && r.cin != r.cfg.code // [R7]
        |=> r.st == S_DISP) else $error("wrong code accepted");
    a_param_next: assert property (r.st == S_MENU && ed[3] && !ed[2] // [R8]
        |=> r.par == (($past(r.par) == P_LAST) ? P_UPD : $past(r.par) + 4'h1))
        else $error("parameter step wrong");
    a_prog_count: assert property (pe && !r.hold && r.st != S_DISP && !clr_tot // [R1]
        |=> r.tacc == $past(r.tacc) + 28'(pow10(r.cfg.tsc[SC_DP+:2])))
        else $error("pulse lost in menu");
    a_hold_stop: assert property (pe && r.hold && !clr_tot // [R14]
        |=> $stable(r.tacc) && $stable(r.tcnt)) else $error("counted below clip-off");
    a_total_tick: assert property (ht && !clr_tot // [R4]
        |=> r.tot == $past(r.tcnt)) else $error("total not republished");
    a_gt_clear: assert property (r.st == S_CONF && ed[4] // [R16]
        |=> r.gt == 64'h0 && r.st == S_MENU) else $error("grand total not cleared");
    a_loc_clear: assert property (clr_tot |=> r.tcnt == 32'h0 && r.tot == 32'h0) // [R15]
        else $error("local clear failed");
    c_menu: cover property (r.st == S_CODE ##1 r.st == S_MENU);
    c_gt_clr: cover property (r.st == S_CONF ##1 r.gt == 64'h0);
    c_div: cover property (r.busy ##1 !r.busy);
endmodule : prt_core

// >>> logic/prt_pkg.sv
package prt_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int HALF_MS = 500;
    localparam int HALF_CYC = HALF_MS * CLK_MHZ * 1000;
    localparam int TMO_S = 10;
    localparam int TMO_CYC = TMO_S * CLK_MHZ * 1000000;
    localparam int LR_S = 2;
    localparam int LR_CYC = LR_S * CLK_MHZ * 1000000;
    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_RSC = 8'h04;
    localparam logic [7:0] A_TSC = 8'h08;
    localparam logic [7:0] A_CLIP = 8'h0C;
    localparam logic [7:0] A_CODE = 8'h10;
    localparam logic [7:0] A_RATE = 8'h14;
    localparam logic [7:0] A_TOT = 8'h18;
    localparam logic [7:0] A_GTL = 8'h1C;
    localparam logic [7:0] A_GTH = 8'h20;
    localparam logic [7:0] A_STAT = 8'h24;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int F_TYPE = 0;
    localparam int F_TB = 4;
    localparam int F_UPD = 8;
    localparam int F_LOW = 12;
    localparam int F_LOC = 13;
    localparam int F_F1 = 16;
    localparam int F_F2 = 20;
    localparam int SC_DP = 28;
    // ----------------------------------------
    // input types and menu
    // ----------------------------------------
    localparam logic [2:0] IT_VOLT = 3'h0;
    localparam logic [2:0] IT_MAG = 3'h1;
    localparam logic [2:0] IT_PROX = 3'h2;
    localparam logic [2:0] IT_SW = 3'h3;
    localparam logic [2:0] IT_OC = 3'h4;
    localparam logic [2:0] N_TB = 3'h2;
    localparam logic [2:0] N_UPD = 3'h5;
    localparam logic [3:0] P_UPD = 4'h0;
    localparam logic [3:0] P_TYPE = 4'h1;
    localparam logic [3:0] P_LOW = 4'h3;
    localparam logic [3:0] P_TB = 4'h5;
    localparam logic [3:0] P_LOC = 4'h9;
    localparam logic [3:0] P_CLR = 4'hA;
    localparam logic [3:0] P_LAST = 4'hB;

    typedef enum logic [4:0] {
        S_DISP = 5'h01,
        S_CODE = 5'h02,
        S_MENU = 5'h04,
        S_EDIT = 5'h08,
        S_CONF = 5'h10
    } prt_state_t;

    typedef struct packed {
        logic [2:0] itype;
        logic [1:0] tb;
        logic [2:0] upd;
        logic lower;
        logic locen;
        logic [3:0] f1;
        logic [3:0] f2;
        logic [31:0] rsc;
        logic [31:0] tsc;
        logic [31:0] clip;
        logic [15:0] code;
    } prt_cfg_t;

    localparam prt_cfg_t CFG_RST = '{itype: IT_OC, tb: 2'h0, upd: 3'h1,
        lower: 1'b1, locen: 1'b0, f1: 4'h0, f2: 4'h0, rsc: 32'h1,
        tsc: 32'h1, clip: 32'h0, code: 16'h0};

    typedef struct packed {
        logic [4:0] s1, s2, s3, lv, lq;
        prt_state_t st;
        logic [3:0] par;
        logic [1:0] dig;
        logic prm;
        logic [15:0] cin;
        logic [29:0] tmo;
        logic [25:0] hc;
        logic [3:0] dc;
        logic win;
        logic [27:0] lrc;
        logic [15:0] pc;
        logic [47:0] num;
        logic [27:0] rem;
        logic [31:0] quo;
        logic [5:0] dn;
        logic busy;
        logic [31:0] rflt;
        logic [27:0] tacc;
        logic [31:0] tcnt, tot, d_rate, d_tot;
        logic [63:0] gt;
        logic hold;
        prt_cfg_t cfg;
        logic a_wr;
        logic [7:0] a_adr;
        logic [31:0] rdata;
        logic rdy;
        logic rsp;
        logic mon, cpr;
    } prt_st_t;
endpackage : prt_pkg

// >>> test/prt_src.sv
module prt_src (
    input wire logic hclk,
    output logic pulse_in,
    output logic btn_cycle,
    output logic btn_up,
    output logic btn_down,
    output logic btn_commit
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    int period = 20;
    initial begin
        {pulse_in, btn_cycle, btn_up, btn_down, btn_commit} = 5'h00;
    end
    // ----------------------------------------
    // flowmeter
    // ----------------------------------------
    // exact period, so a rate window holds a known count
    always @(posedge hclk) begin
        if (left > 0) begin
            pulse_in <= 1'b1;
            repeat (5) @(posedge hclk);
            pulse_in <= 1'b0;
            repeat (period - 6) @(posedge hclk);
            left--;
        end
    end
    task automatic run(input int n, input int p);
        period = p;
        left = n;
    endtask : run
    // ----------------------------------------
    // front panel
    // ----------------------------------------
    // long gap after release so the synchroniser settles
    task automatic press(input logic [3:0] m, input int hold);
        @(posedge hclk);
        {btn_cycle, btn_up, btn_down, btn_commit} <= m;
        repeat (hold) @(posedge hclk);
        {btn_cycle, btn_up, btn_down, btn_commit} <= 4'h0;
        repeat (12) @(posedge hclk);
    endtask : press
endmodule : prt_src

// >>> test/tb.sv
module tb import prt_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HC = 200;
    localparam int TC = 2000;
    localparam int LC = 100;
    localparam logic [3:0] B_CYC = 4'h8;
    localparam logic [3:0] B_UP = 4'h4;
    localparam logic [3:0] B_DN = 4'h2;
    localparam logic [3:0] B_COM = 4'h1;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, disp_rate, disp_total, q, g0, t0;
    logic pulse_in, btn_cycle, btn_up, btn_down, btn_commit;
    logic lower_display_on, hold_ind, menu_on, code_prompt;
    logic [3:0] menu_sel;
    wire logic hready;
    int err_total = 0;
    int cmp_count = 0;
    assign hready = hreadyout;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
    prt_core #(.HALF_CYC_P(HC), .TMO_CYC_P(TC), .LR_CYC_P(LC)) i_prt_core (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pulse_in(pulse_in), .btn_cycle(btn_cycle), .btn_up(btn_up),
        .btn_down(btn_down), .btn_commit(btn_commit), .disp_rate(disp_rate),
        .disp_total(disp_total), .lower_display_on(lower_display_on),
        .hold_ind(hold_ind), .menu_on(menu_on), .code_prompt(code_prompt),
        .menu_sel(menu_sel));
    prt_src i_prt_src (.hclk(hclk), .pulse_in(pulse_in), .btn_cycle(btn_cycle),
        .btn_up(btn_up), .btn_down(btn_down), .btn_commit(btn_commit));
    // ----------------------------------------
    // bus and panel tasks
    // ----------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        `CHK(q, e)
    endtask : rd
    task automatic btn(input logic [3:0] m);
        i_prt_src.press(m, 10);
    endtask : btn
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // whole run is about 15k cycles; this allows twice that
    initial begin
        #300000;
        err_total++;
        final_report();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(A_CFG, 32'h00001104);
        rd(A_RSC, 32'h00000001);
        rd(A_TSC, 32'h00000001);
        rd(A_CODE, 32'h00000000);
        rd(8'h30, 32'h00000000);
        `CHK(lower_display_on, 1'b1)
        `CHK(hresp, 1'b0)
        for (int i = 0; i < 5; i++) begin
            wr(A_CFG, 32'h00001100 | 32'(i));
            rd(A_CFG, 32'h00001100 | 32'(i));
        end
        $display("test reset done");
        i_prt_src.run(100000, 20);
        for (int i = 0; i < 3; i++) begin
            wr(A_CFG, 32'h00001104 | (32'(i) << 4));
            repeat (1200) @(posedge hclk);
            rd(A_RATE, (i == 0) ? 32'd20 : (i == 1) ? 32'd1200 : 32'd72000);
        end
        wr(A_CFG, 32'h00911104);
        repeat (1200) @(posedge hclk);
        rd(A_RATE, 32'd20);
        wr(A_CFG, 32'h00011114);
        repeat (1200) @(posedge hclk);
        bus(1'b0, A_RATE, 32'h00000000);
        `CHK(q > 32'd20 && q < 32'd1200, 1'b1)
        wr(A_CFG, 32'h00001104);
        wr(A_RSC, 32'h10000005);
        repeat (1200) @(posedge hclk);
        rd(A_RATE, 32'd40);
        `CHK(disp_rate, 32'd40)
        `CHK(hold_ind, 1'b0)
        wr(A_CLIP, 32'd1000);
        repeat (1200) @(posedge hclk);
        `CHK(hold_ind, 1'b1)
        bus(1'b0, A_TOT, 32'h00000000);
        t0 = q;
        repeat (1200) @(posedge hclk);
        rd(A_TOT, t0);
        i_prt_src.run(0, 20);
        repeat (30) @(posedge hclk);
        wr(A_CLIP, 32'd0);
        wr(A_RSC, 32'd1);
        $display("test rate done");
        wr(A_CFG, 32'h00003104);
        i_prt_src.press(B_UP | B_DN, LC - 40);
        repeat (500) @(posedge hclk);
        rd(A_TOT, t0);
        i_prt_src.press(B_UP | B_DN, LC + 40);
        repeat (500) @(posedge hclk);
        rd(A_TOT, 32'd0);
        bus(1'b0, A_GTL, 32'h00000000);
        g0 = q;
        wr(A_TSC, 32'd3);
        btn(B_CYC | B_COM);
        `CHK(menu_on, 1'b1)
        `CHK(code_prompt, 1'b0)
        `CHK(menu_sel, 4'h0)
        i_prt_src.run(30, 20);
        wait (i_prt_src.left <= 0);
        repeat (300) @(posedge hclk);
        rd(A_TOT, 32'd10);
        rd(A_GTL, g0 + 32'd10);
        $display("test total done");
        btn(B_CYC);
        btn(B_DN);
        btn(B_COM);
        rd(A_CFG, 32'h00003004);
        btn(B_CYC);
        btn(B_UP);
        btn(B_COM);
        rd(A_CFG, 32'h00003104);
        btn(B_DN);
        `CHK(menu_sel, 4'h1)
        btn(B_UP);
        `CHK(menu_sel, 4'h0)
        btn(B_UP);
        `CHK(menu_sel, 4'hB)
        btn(B_UP);
        `CHK(menu_sel, 4'hA)
        btn(B_CYC);
        rd(A_GTL, g0 + 32'd10);
        btn(B_COM);
        rd(A_GTL, 32'd0);
        rd(A_GTH, 32'd0);
        `CHK(menu_on, 1'b1)
        btn(B_COM);
        `CHK(menu_on, 1'b0)
        $display("test menu done");
        wr(A_CODE, 32'h00000012);
        btn(B_CYC | B_COM);
        `CHK(code_prompt, 1'b1)
        btn(B_COM);
        `CHK(menu_on, 1'b0)
        btn(B_CYC | B_COM);
        btn(B_CYC);
        btn(B_UP);
        btn(B_UP);
        btn(B_CYC);
        btn(B_UP);
        btn(B_COM);
        `CHK(menu_on, 1'b1)
        `CHK(code_prompt, 1'b0)
        `CHK(menu_sel, 4'h0)
        btn(B_COM);
        btn(B_CYC | B_COM);
        repeat (TC - 100) @(posedge hclk);
        `CHK(menu_on, 1'b1)
        repeat (200) @(posedge hclk);
        `CHK(menu_on, 1'b0)
        $display("test code done");
        `CHK(disp_total, 32'd10)
        final_report();
    end
endmodule : tb
